// >>> rtl/lsd_defines.vh
// Shared constants for the four-lane seven-slot serializer and deserializer.
`ifndef LSD_DEFINES_VH
`define LSD_DEFINES_VH

// Word, lane and slot geometry.
`define LSD_WORD_W          28
`define LSD_LANES           4
`define LSD_SLOTS           7
`define LSD_LAST_SLOT       3'h6
`define LSD_CLK_HIGH_SLOTS  3'h4

// Reference clock period in nanoseconds.
`define LSD_REF_PERIOD_NS   25

// Legal link clock period per bit slot, in nanoseconds and in reference cycles.
`define LSD_RX_CLK_MIN_NS   15
`define LSD_RX_CLK_MAX_NS   50
`define LSD_SLOT_MIN_CYC    ((`LSD_RX_CLK_MIN_NS + `LSD_REF_PERIOD_NS - 1) / `LSD_REF_PERIOD_NS)
`define LSD_SLOT_MAX_CYC    (`LSD_RX_CLK_MAX_NS / `LSD_REF_PERIOD_NS)
`define LSD_FRAME_MIN_CYC   (`LSD_SLOTS * `LSD_SLOT_MIN_CYC)
`define LSD_FRAME_MAX_CYC   (`LSD_SLOTS * `LSD_SLOT_MAX_CYC)

// Receiver lock time in milliseconds and in reference cycles.
`define LSD_RX_LOCK_MS      10
`define LSD_RX_LOCK_CYCLES  ((`LSD_RX_LOCK_MS * 1000000) / `LSD_REF_PERIOD_NS)

`endif

// >>> rtl/lsd_pair_buffer.v
// Two-entry word buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
`include "lsd_defines.vh"

module lsd_pair_buffer
(
   input  wire                     ref_clk,
   input  wire                     rst,
   input  wire                     in_valid,
   output wire                     in_ready,
   input  wire [`LSD_WORD_W-1:0]   in_data,
   output wire                     out_valid,
   input  wire                     out_ready,
   output wire [`LSD_WORD_W-1:0]   out_data
);

   reg  [`LSD_WORD_W-1:0] store [0:1];
   reg                    wr_idx;
   reg                    rd_idx;
   reg  [1:0]             fill;
   wire                   push;
   wire                   pop;

   // Full and empty come straight from the fill count.
   assign in_ready  = (fill != 2'h2);
   assign out_valid = (fill != 2'h0);
   assign out_data  = store[rd_idx];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Pointers and count move on push and pop; both may happen in one cycle.
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         wr_idx <= 1'b0;
         rd_idx <= 1'b0;
         fill   <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wr_idx <= ~wr_idx;
         end
         if (pop)
         begin
            rd_idx <= ~rd_idx;
         end
         if (push & ~pop)
         begin
            fill <= fill + 2'h1;
         end
         else if (pop & ~push)
         begin
            fill <= fill - 2'h1;
         end
      end
   end

   // Storage is written only on an accepted push.
   always @(posedge ref_clk)
   begin
      if (push)
      begin
         store[wr_idx] <= in_data;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/lsd_serdes.v
// Four-lane seven-slot serializer and matching deserializer for 28-bit words.
// Operation
// - Seven slots per word on four lanes.
// - Lane 0 sends 7,6,4,3,2,1,0.
// - Lane 1 sends 18,15,14,13,12,9,8.
// - Lane 2 sends 26,25,24,22,21,20,19.
// - Lane 3 sends 23,17,16,11,10,5,27.
// - Capture input word on strobe rising edge.
// - Transmit power-down releases all lane outputs.
// - Receive power-down zeroes outputs within 1 us.
// - Receiver locks within 10 ms.
// - Link clock period stays 15 to 50 ns.
// - Seven evenly spaced sample points per frame; code samples on seven consecutive cycles from the clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "lsd_defines.vh"

module lsd_serdes
#(
   parameter LOCK_CYCLES = `LSD_RX_LOCK_CYCLES
)
(
   input  wire                     ref_clk,
   input  wire                     rst,
   input  wire                     strobe_clock_in,
   input  wire [`LSD_WORD_W-1:0]   parallel_data_in,
   input  wire                     tx_power_down_n,
   output wire                     tx_ready,
   output reg  [`LSD_LANES-1:0]    serial_data_lane,
   output reg                      serial_data_lane_oe_n,
   output reg                      forwarded_clock_lane,
   output reg                      forwarded_clock_lane_oe_n,
   input  wire                     rx_power_down_n,
   input  wire [`LSD_LANES-1:0]    serial_data_rx,
   input  wire                     forwarded_clock_rx,
   output reg  [`LSD_WORD_W-1:0]   parallel_data_out,
   output reg                      restored_clock_out,
   output reg                      rx_locked
);

   ////////////////////////////////////////////////////////////////////////////
   // Lane and slot to word bit index, shared by both directions.
   function [4:0] map_index;
      input [1:0] lane;
      input [2:0] slot;
      begin
         case ({lane, slot})
            5'h00: map_index = 5'h07;
            5'h01: map_index = 5'h06;
            5'h02: map_index = 5'h04;
            5'h03: map_index = 5'h03;
            5'h04: map_index = 5'h02;
            5'h05: map_index = 5'h01;
            5'h06: map_index = 5'h00;
            5'h08: map_index = 5'h12;
            5'h09: map_index = 5'h0F;
            5'h0A: map_index = 5'h0E;
            5'h0B: map_index = 5'h0D;
            5'h0C: map_index = 5'h0C;
            5'h0D: map_index = 5'h09;
            5'h0E: map_index = 5'h08;
            5'h10: map_index = 5'h1A;
            5'h11: map_index = 5'h19;
            5'h12: map_index = 5'h18;
            5'h13: map_index = 5'h16;
            5'h14: map_index = 5'h15;
            5'h15: map_index = 5'h14;
            5'h16: map_index = 5'h13;
            5'h18: map_index = 5'h17;
            5'h19: map_index = 5'h11;
            5'h1A: map_index = 5'h10;
            5'h1B: map_index = 5'h0B;
            5'h1C: map_index = 5'h0A;
            5'h1D: map_index = 5'h05;
            5'h1E: map_index = 5'h1B;
            default: map_index = 5'h00;
         endcase
      end
   endfunction

   // Picks the four lane bits of one slot out of a word.
   function [`LSD_LANES-1:0] lane_bits;
      input [`LSD_WORD_W-1:0] word;
      input [2:0]             slot;
      integer                 l;
      begin
         lane_bits = 4'h0;
         for (l = 0; l < `LSD_LANES; l = l + 1)
            lane_bits[l] = word[map_index(l[1:0], slot)];
      end
   endfunction

   // Puts the four lane bits of one slot back into a word.
   function [`LSD_WORD_W-1:0] place;
      input [`LSD_WORD_W-1:0] word;
      input [`LSD_LANES-1:0]  bits;
      input [2:0]             slot;
      integer                 l;
      begin
         place = word;
         for (l = 0; l < `LSD_LANES; l = l + 1)
            place[map_index(l[1:0], slot)] = bits[l];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Transmit side: two-stage synchronisers for strobe, data and power-down.
   reg  [`LSD_WORD_W-1:0] txd_s1;
   reg  [`LSD_WORD_W-1:0] txd_s2;
   reg  [2:0]             stb_s;
   reg  [1:0]             txpd_s;
   wire                   tx_on;
   wire                   stb_rise;

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         txd_s1 <= 28'h0000000;
         txd_s2 <= 28'h0000000;
         stb_s  <= 3'h0;
         txpd_s <= 2'h0;
      end
      else
      begin
         txd_s1 <= parallel_data_in;
         txd_s2 <= txd_s1;
         stb_s  <= {stb_s[1:0], strobe_clock_in};
         txpd_s <= {txpd_s[0], tx_power_down_n};
      end
   end

   assign tx_on    = txpd_s[1];
   assign stb_rise = stb_s[1] & ~stb_s[2];

   // Captured words wait in the buffer until the serializer is free.
   wire                   buf_valid;
   wire                   buf_take;
   wire [`LSD_WORD_W-1:0] buf_data;
   reg                    tx_busy;
   reg  [2:0]             tx_slot;
   reg  [`LSD_WORD_W-1:0] tx_word;
   wire [2:0]             next_slot;

   assign buf_take  = tx_on & buf_valid & (~tx_busy | (tx_slot == `LSD_LAST_SLOT));
   assign next_slot = tx_slot + 3'h1;

   lsd_pair_buffer u_buffer
   (
      .ref_clk   (ref_clk),
      .rst       (rst | ~tx_on),
      .in_valid  (stb_rise & tx_on),
      .in_ready  (tx_ready),
      .in_data   (txd_s2),
      .out_valid (buf_valid),
      .out_ready (buf_take),
      .out_data  (buf_data)
   );

   // Serializer: one slot per cycle, seven per word, clock high for four.
   always @(posedge ref_clk)
   begin
      if (rst | ~tx_on)
      begin
         tx_busy              <= 1'b0;
         tx_slot              <= 3'h0;
         tx_word              <= 28'h0000000;
         serial_data_lane     <= 4'h0;
         forwarded_clock_lane <= 1'b0;
      end
      else if (buf_take)
      begin
         tx_busy              <= 1'b1;
         tx_slot              <= 3'h0;
         tx_word              <= buf_data;
         serial_data_lane     <= lane_bits(buf_data, 3'h0);
         forwarded_clock_lane <= 1'b1;
      end
      else if (tx_busy)
      begin
         if (tx_slot == `LSD_LAST_SLOT)
         begin
            tx_busy              <= 1'b0;
            forwarded_clock_lane <= 1'b0;
         end
         else
         begin
            tx_slot              <= next_slot;
            serial_data_lane     <= lane_bits(tx_word, next_slot);
            forwarded_clock_lane <= (next_slot < `LSD_CLK_HIGH_SLOTS);
         end
      end
   end

   // Lane drivers are released while powered down.
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         serial_data_lane_oe_n     <= 1'b1;
         forwarded_clock_lane_oe_n <= 1'b1;
      end
      else
      begin
         serial_data_lane_oe_n     <= ~tx_on;
         forwarded_clock_lane_oe_n <= ~tx_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive side: synchronisers for link clock, lanes and power-down.
   reg  [2:0]             fck_s;
   reg  [`LSD_LANES-1:0]  rxd_s1;
   reg  [`LSD_LANES-1:0]  rxd_s2;
   reg  [1:0]             rxpd_s;
   wire                   rx_on;
   wire                   fck_rise;

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         fck_s  <= 3'h0;
         rxd_s1 <= 4'h0;
         rxd_s2 <= 4'h0;
         rxpd_s <= 2'h0;
      end
      else
      begin
         fck_s  <= {fck_s[1:0], forwarded_clock_rx};
         rxd_s1 <= serial_data_rx;
         rxd_s2 <= rxd_s1;
         rxpd_s <= {rxpd_s[0], rx_power_down_n};
      end
   end

   assign rx_on    = rxpd_s[1];
   assign fck_rise = fck_s[1] & ~fck_s[2];

   // Frame spacing monitor and lock counter.
   reg  [4:0]  gap;
   reg  [18:0] lock_cnt;
   wire        gap_ok;

   assign gap_ok = (gap >= `LSD_FRAME_MIN_CYC - 1) && (gap <= `LSD_FRAME_MAX_CYC - 1);

   always @(posedge ref_clk)
   begin
      if (rst | ~rx_on)
      begin
         gap       <= 5'h00;
         lock_cnt  <= 19'h00000;
         rx_locked <= 1'b0;
      end
      else
      begin
         if (fck_rise)
            gap <= 5'h00;
         else if (gap != 5'h1F)
            gap <= gap + 5'h01;
         if ((fck_rise & ~gap_ok) | (gap > `LSD_FRAME_MAX_CYC))
         begin
            lock_cnt  <= 19'h00000;
            rx_locked <= 1'b0;
         end
         else if (lock_cnt >= LOCK_CYCLES[18:0] - 19'h00001)
            rx_locked <= 1'b1;
         else
            lock_cnt <= lock_cnt + 19'h00001;
      end
   end

   // Slot sampler: one sample per cycle from the link clock edge on.
   reg                    rx_busy;
   reg  [2:0]             rx_slot;
   reg  [`LSD_WORD_W-1:0] rx_word;
   reg  [2:0]             rck_cnt;

   always @(posedge ref_clk)
   begin
      if (rst | ~rx_on)
      begin
         rx_busy            <= 1'b0;
         rx_slot            <= 3'h0;
         rx_word            <= 28'h0000000;
         rck_cnt            <= 3'h0;
         parallel_data_out  <= 28'h0000000;
         restored_clock_out <= 1'b0;
      end
      else
      begin
         restored_clock_out <= (rck_cnt != 3'h0);
         if (rck_cnt != 3'h0)
            rck_cnt <= rck_cnt - 3'h1;
         if (fck_rise)
         begin
            rx_busy <= 1'b1;
            rx_slot <= 3'h1;
            rx_word <= place(28'h0000000, rxd_s2, 3'h0);
         end
         else if (rx_busy)
         begin
            rx_slot <= rx_slot + 3'h1;
            rx_word <= place(rx_word, rxd_s2, rx_slot);
            if (rx_slot == `LSD_LAST_SLOT)
            begin
               rx_busy <= 1'b0;
               if (rx_locked)
               begin
                  parallel_data_out <= place(rx_word, rxd_s2, rx_slot);
                  rck_cnt           <= `LSD_CLK_HIGH_SLOTS;
               end
            end
         end
      end
   end

endmodule
`default_nettype wire

// >>> verif/lsd_serdes_assertions.sv
// Concurrent checks on the serializer and deserializer ports.
`timescale 1ns/1ps
`default_nettype none
module lsd_serdes_checker
#(
   parameter LOCK_CYCLES = 20
)
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        tx_power_down_n,
   input wire logic [3:0]  serial_data_lane,
   input wire logic        serial_data_lane_oe_n,
   input wire logic        forwarded_clock_lane,
   input wire logic        forwarded_clock_lane_oe_n,
   input wire logic        rx_power_down_n,
   input wire logic [27:0] parallel_data_out,
   input wire logic        restored_clock_out,
   input wire logic        rx_locked
);
   int up_cnt;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // Counts cycles since reset or receive power-down, saturating at the lock time.
   always @(posedge ref_clk)
   begin
      if (rst || !rx_power_down_n)
         up_cnt <= 0;
      else if (up_cnt < LOCK_CYCLES)
         up_cnt <= up_cnt + 1;
   end
   property p_oe_pair;
      serial_data_lane_oe_n == forwarded_clock_lane_oe_n;
   endproperty
   a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
   property p_pd_release;
      !tx_power_down_n [*4] |-> serial_data_lane_oe_n;
   endproperty
   a_pd_release: assert property (p_pd_release) else $error("lanes driven in power-down");
   property p_lanes_off;
      serial_data_lane_oe_n |-> serial_data_lane == 4'h0 && !forwarded_clock_lane;
   endproperty
   a_lanes_off: assert property (p_lanes_off) else $error("released lanes not idle");
   property p_fclk_frame;
      disable iff (rst || !tx_power_down_n)
      $rose(forwarded_clock_lane) |-> forwarded_clock_lane [*4] ##1 !forwarded_clock_lane [*3];
   endproperty
   a_fclk_frame: assert property (p_fclk_frame) else $error("bad clock lane frame");
   property p_rclk_high;
      disable iff (rst || !rx_power_down_n)
      $rose(restored_clock_out) |-> restored_clock_out [*4] ##1 !restored_clock_out;
   endproperty
   a_rclk_high: assert property (p_rclk_high) else $error("bad restored clock");
   property p_rx_zero;
      !rx_power_down_n [*4] |-> parallel_data_out == 28'h0 && !rx_locked;
   endproperty
   a_rx_zero: assert property (p_rx_zero) else $error("outputs not low");
   property p_out_locked;
      $changed(parallel_data_out) && parallel_data_out != 28'h0 |-> rx_locked || $past(rx_locked);
   endproperty
   a_out_locked: assert property (p_out_locked) else $error("word before lock");
   property p_lock_time;
      $rose(rx_locked) |-> up_cnt >= LOCK_CYCLES;
   endproperty
   a_lock_time: assert property (p_lock_time) else $error("lock too early");
endmodule
bind lsd_serdes lsd_serdes_checker #(.LOCK_CYCLES(LOCK_CYCLES)) lsd_serdes_checker_i
(
   .ref_clk(ref_clk),
   .rst(rst),
   .tx_power_down_n(tx_power_down_n),
   .serial_data_lane(serial_data_lane),
   .serial_data_lane_oe_n(serial_data_lane_oe_n),
   .forwarded_clock_lane(forwarded_clock_lane),
   .forwarded_clock_lane_oe_n(forwarded_clock_lane_oe_n),
   .rx_power_down_n(rx_power_down_n),
   .parallel_data_out(parallel_data_out),
   .restored_clock_out(restored_clock_out),
   .rx_locked(rx_locked)
);
`default_nettype wire

// >>> verif/lsd_far_end.sv
// Far-end model that loops the transmit lanes back into the receiver.
`timescale 1ns/1ps
`default_nettype none
module lsd_far_end
(
   input  wire logic       ref_clk,
   input  wire logic [3:0] lane_in,
   input  wire logic       lane_oe_n,
   input  wire logic       clk_in,
   input  wire logic       clk_oe_n,
   output logic      [3:0] lane_out,
   output logic            clk_out
);
   logic [3:0] last_lane = 4'h0;
   logic       last_clk = 1'b0;
   ////////////////////////////////////////
   // Keeps the last driven level so a released line can show its inverse.
   always @(posedge ref_clk)
   begin
      if (!lane_oe_n)
         last_lane <= lane_in;
      if (!clk_oe_n)
         last_clk <= clk_in;
   end
   // Driven lines pass straight through; released lines carry no stale level.
   assign lane_out = lane_oe_n ? ~last_lane : lane_in;
   assign clk_out = clk_oe_n ? ~last_clk : clk_in;
endmodule
`default_nettype wire

// >>> verif/lsd_serdes_test.sv
// Self-checking bench for the four-lane serializer and deserializer.
`timescale 1ns/1ps
`default_nettype none
module lsd_serdes_test;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        strobe_clock_in = 1'b0;
   logic [27:0] parallel_data_in = 28'h0;
   logic        tx_power_down_n = 1'b1;
   logic        rx_power_down_n = 1'b1;
   wire  [3:0]  serial_data_lane;
   wire         serial_data_lane_oe_n;
   wire         forwarded_clock_lane;
   wire         forwarded_clock_lane_oe_n;
   wire  [3:0]  serial_data_rx;
   wire         forwarded_clock_rx;
   wire  [27:0] parallel_data_out;
   wire         restored_clock_out;
   wire         rx_locked;
   wire         tx_ready;
   int          num_errors = 0;
   int          n_compared = 0;
   int          slot_bit [4][7] = '{'{7, 6, 4, 3, 2, 1, 0}, '{18, 15, 14, 13, 12, 9, 8},
                                   '{26, 25, 24, 22, 21, 20, 19}, '{23, 17, 16, 11, 10, 5, 27}};
   lsd_serdes #(.LOCK_CYCLES(20)) lsd_serdes_i
   (
      .ref_clk(ref_clk), .rst(rst), .strobe_clock_in(strobe_clock_in),
      .parallel_data_in(parallel_data_in), .tx_power_down_n(tx_power_down_n),
      .tx_ready(tx_ready), .serial_data_lane(serial_data_lane),
      .serial_data_lane_oe_n(serial_data_lane_oe_n), .forwarded_clock_lane(forwarded_clock_lane),
      .forwarded_clock_lane_oe_n(forwarded_clock_lane_oe_n), .rx_power_down_n(rx_power_down_n),
      .serial_data_rx(serial_data_rx), .forwarded_clock_rx(forwarded_clock_rx),
      .parallel_data_out(parallel_data_out), .restored_clock_out(restored_clock_out),
      .rx_locked(rx_locked)
   );
   lsd_far_end lsd_far_end_i
   (
      .ref_clk(ref_clk), .lane_in(serial_data_lane), .lane_oe_n(serial_data_lane_oe_n),
      .clk_in(forwarded_clock_lane), .clk_oe_n(forwarded_clock_lane_oe_n),
      .lane_out(serial_data_rx), .clk_out(forwarded_clock_rx)
   );
   ////////////////////////////////////////
   // Reference clock.
   always #12.5 ref_clk = ~ref_clk;
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task report_and_stop;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   // One strobe period of 8 cycles; data is steady around the rising edge.
   task pump(input logic [27:0] w);
      strobe_clock_in <= 1'b0;
      parallel_data_in <= w;
      repeat (4) @(posedge ref_clk);
      strobe_clock_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask
   task check_map(input logic [27:0] w);
      logic [3:0] exp;
      int n;
      fork
         pump(w);
         begin
            n = 0;
            while (forwarded_clock_lane !== 1'b1 && n < 20)
            begin
               @(negedge ref_clk);
               n++;
            end
            for (int s = 0; s < 7; s++)
            begin
               for (int l = 0; l < 4; l++)
                  exp[l] = w[slot_bit[l][s]];
               check("lanes", serial_data_lane, exp);
               check("clock lane", forwarded_clock_lane, s < 4);
               @(negedge ref_clk);
            end
         end
      join
      @(posedge ref_clk);
   endtask
   task check_loop;
      logic [27:0] sent [10];
      for (int i = 0; i < 10; i++)
      begin
         sent[i] = 28'hF0F0F0F ^ (i * 28'h1234567);
         pump(sent[i]);
         if (i >= 4)
            check("restored word", parallel_data_out, sent[i-2]);
      end
      check("locked", rx_locked, 1'b1);
      settle(2);
      check("restored clock", restored_clock_out, 1'b1);
      check("restored word", parallel_data_out, sent[8]);
      @(posedge ref_clk);
   endtask
   task check_rx_off;
      rx_power_down_n <= 1'b0;
      settle(39);
      check("word off", parallel_data_out, 28'h0);
      check("lock off", rx_locked, 1'b0);
      @(posedge ref_clk);
      rx_power_down_n <= 1'b1;
   endtask
   task check_tx_off;
      tx_power_down_n <= 1'b0;
      settle(5);
      check("lane enable", serial_data_lane_oe_n, 1'b1);
      check("clock enable", forwarded_clock_lane_oe_n, 1'b1);
      @(posedge ref_clk);
      tx_power_down_n <= 1'b1;
      settle(5);
      check("lane enable", serial_data_lane_oe_n, 1'b0);
      @(posedge ref_clk);
   endtask
   // Strobes every 4 cycles outrun the serializer until the buffer refuses.
   task check_burst;
      logic full;
      full = 1'b0;
      for (int i = 0; i < 24; i++)
      begin
         strobe_clock_in <= i[1];
         parallel_data_in <= 28'h0 + i;
         @(negedge ref_clk);
         if (tx_ready === 1'b0)
            full = 1'b1;
         @(posedge ref_clk);
      end
      check("buffer full", full, 1'b1);
      settle(60);
      check("buffer drained", tx_ready, 1'b1);
   endtask
   // Main sequence.
   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (5) @(posedge ref_clk);
      check_map(28'hA5C396E);
      check_map(28'h5A3C691);
      check_loop;
      check_rx_off;
      check_tx_off;
      check_burst;
      report_and_stop;
   end
   // Cuts the run short if a scenario hangs.
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      num_errors++;
      report_and_stop;
   end
endmodule
`default_nettype wire
